// file: inc/msrc_consts.svh
`ifndef MSRC_CONSTS_SVH
`define MSRC_CONSTS_SVH

// Register byte addresses
`define MSRC_ADDR_SOFT_RESET    8'h00
`define MSRC_ADDR_BYTE_REG8     8'h04
`define MSRC_ADDR_MODE_CTRL     8'h08
`define MSRC_ADDR_STATUS        8'h0C

// Field positions
`define MSRC_SOFT_RESET_BIT     3
`define MSRC_NT_SOFT_BIT        0
`define MSRC_NT_SOFT_EN_BIT     1
`define MSRC_FREF_OUT_EN_BIT    0
`define MSRC_FMT_LSB            1

// Reset values
`define MSRC_SOFT_RESET_RST     8'h00
`define MSRC_BYTE_REG8_RST      8'h00
`define MSRC_MODE_CTRL_RST      8'h00

// Timing
`define MSRC_CLK_MHZ_X100       2048
`define MSRC_RESET_MIN_PERIODS  6
`define MSRC_FRAME_DIV          16'h09FF
`define MSRC_DCL_DIV            4'h4

`endif

// file: inc/msrc_pkg.sv
package msrc_pkg;
    typedef enum logic [1:0] {
        MSRC_FMT_SHORT,
        MSRC_FMT_LONG,
        MSRC_FMT_GCI,
        MSRC_FMT_TSA
    } msrc_fmt_e;

    typedef enum logic [1:0] {
        MSRC_PORT_NONE,
        MSRC_PORT_SERIAL,
        MSRC_PORT_PARALLEL
    } msrc_port_e;
endpackage

// file: verilog/msrc_reset_sync.sv
`timescale 1ns/1ps
`include "msrc_consts.svh"

module msrc_reset_sync (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    // Reset sources
    input  wire logic hw_reset_n,
    input  wire logic soft_reset,
    // Combined reset, active high
    output logic      core_reset
);
    logic meta_r;
    logic sync_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else if (ce) begin
            meta_r <= hw_reset_n;
            sync_r <= meta_r;
        end
    end

    assign core_reset = !sync_r || soft_reset;

    sync_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        soft_reset |-> core_reset) else $error("soft reset not combined");
endmodule

// file: verilog/msrc_top.sv
`timescale 1ns/1ps
`include "msrc_consts.svh"

module msrc_top (
    // Clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Straps
    input  wire logic        hw_reset_n,
    input  wire logic        network_or_line_select,
    input  wire logic        host_or_bus_mode_select,
    input  wire logic        parallel_serial_select,
    input  wire logic        master_timing,
    // Mode outputs
    output logic             core_reset,
    output logic             nt_mode,
    output logic             host_mode,
    output logic             parallel_port_en,
    output logic             serial_port_en,
    output logic [1:0]       link_format,
    output logic             line_terminate,
    output logic             wakeup_detect_en,
    // TDM master clocks
    output logic             tdm_data_clock,
    output logic             receive_frame_sync,
    // Frequency reference pin
    input  wire logic        frequency_reference_pin_i,
    output logic             frequency_reference_pin_o,
    output logic             frequency_reference_pin_oe,
    output logic             fref_in_valid
);
    //==========================================================
    // Register state
    logic [7:0]  soft_reset_holder_r;
    logic [7:0]  byte_reg8_r;
    logic [7:0]  mode_ctrl_r;
    logic        aw_got_r;
    logic        w_got_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        wr_fire;
    logic [7:0]  status_w;

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] r);
        return a[7:2] == r[7:2];
    endfunction

    function automatic logic addr_known(input logic [7:0] a);
        return addr_hit(a, `MSRC_ADDR_SOFT_RESET) || addr_hit(a, `MSRC_ADDR_BYTE_REG8)
            || addr_hit(a, `MSRC_ADDR_MODE_CTRL) || addr_hit(a, `MSRC_ADDR_STATUS);
    endfunction

    //==========================================================
    // Reset combine
    msrc_reset_sync u_rst (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .ce         (ce),
        .hw_reset_n (hw_reset_n),
        .soft_reset (soft_reset_holder_r[`MSRC_SOFT_RESET_BIT]),
        .core_reset (core_reset)
    );

    //==========================================================
    // AXI write channel
    assign s_axi_awready = ce && !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready  = ce && !w_got_r && !s_axi_bvalid;
    assign wr_fire       = aw_got_r && w_got_r && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            awaddr_r     <= 8'h00;
            wdata_r      <= 32'h0000_0000;
            wstrb_r      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_known(awaddr_r) ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    //==========================================================
    // Control registers
    // Soft reset bit survives core reset so software can release it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_reset_holder_r <= `MSRC_SOFT_RESET_RST;
        end else if (ce) begin
            if (wr_fire && wstrb_r[0] && addr_hit(awaddr_r, `MSRC_ADDR_SOFT_RESET)) begin
                soft_reset_holder_r <= wdata_r[7:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            byte_reg8_r <= `MSRC_BYTE_REG8_RST;
            mode_ctrl_r <= `MSRC_MODE_CTRL_RST;
        end else if (ce && core_reset) begin
            byte_reg8_r <= `MSRC_BYTE_REG8_RST;
            mode_ctrl_r <= `MSRC_MODE_CTRL_RST;
        end else if (ce && wr_fire && wstrb_r[0]) begin
            if (addr_hit(awaddr_r, `MSRC_ADDR_BYTE_REG8)) begin
                byte_reg8_r <= wdata_r[7:0];
            end else if (addr_hit(awaddr_r, `MSRC_ADDR_MODE_CTRL)) begin
                mode_ctrl_r <= wdata_r[7:0];
            end
        end
    end

    //==========================================================
    // AXI read channel
    assign s_axi_arready = ce && !s_axi_rvalid;
    assign status_w = {1'b0, fref_in_valid, link_format, parallel_port_en,
                       host_mode, nt_mode, core_reset};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'b00;
                if (addr_hit(s_axi_araddr, `MSRC_ADDR_SOFT_RESET)) begin
                    s_axi_rdata <= {24'h00_0000, soft_reset_holder_r};
                end else if (addr_hit(s_axi_araddr, `MSRC_ADDR_BYTE_REG8)) begin
                    s_axi_rdata <= {24'h00_0000, byte_reg8_r};
                end else if (addr_hit(s_axi_araddr, `MSRC_ADDR_MODE_CTRL)) begin
                    s_axi_rdata <= {24'h00_0000, mode_ctrl_r};
                end else if (addr_hit(s_axi_araddr, `MSRC_ADDR_STATUS)) begin
                    s_axi_rdata <= {24'h00_0000, status_w};
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    //==========================================================
    // Mode decode
    always_comb begin
        if (byte_reg8_r[`MSRC_NT_SOFT_EN_BIT]) begin
            nt_mode = byte_reg8_r[`MSRC_NT_SOFT_BIT];
        end else begin
            nt_mode = network_or_line_select;
        end
    end

    assign host_mode        = host_or_bus_mode_select;
    // Bus mode forces both ports off by gating with host_mode, whatever the strap
    assign parallel_port_en = host_mode && parallel_serial_select;
    assign serial_port_en   = host_mode && !parallel_serial_select;
    always_comb begin
        if (host_mode) begin
            link_format = mode_ctrl_r[`MSRC_FMT_LSB +: 2];
        end else begin
            link_format = msrc_pkg::MSRC_FMT_GCI;
        end
    end

    assign line_terminate   = core_reset;
    assign wakeup_detect_en = !core_reset;

    //==========================================================
    // Master TDM clocks, halted in reset
    logic [15:0] frame_cnt_r;
    logic [3:0]  dcl_cnt_r;
    logic        clk_run;

    assign clk_run = master_timing && host_mode && !core_reset;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_cnt_r        <= 16'h0000;
            dcl_cnt_r          <= 4'h0;
            tdm_data_clock     <= 1'b0;
            receive_frame_sync <= 1'b0;
        end else if (ce) begin
            if (!clk_run) begin
                frame_cnt_r        <= 16'h0000;
                dcl_cnt_r          <= 4'h0;
                tdm_data_clock     <= 1'b0;
                receive_frame_sync <= 1'b0;
            end else begin
                frame_cnt_r <= (frame_cnt_r == `MSRC_FRAME_DIV) ? 16'h0000
                             : frame_cnt_r + 16'h0001;
                receive_frame_sync <= (frame_cnt_r == 16'h0000);
                if (dcl_cnt_r == `MSRC_DCL_DIV) begin
                    dcl_cnt_r      <= 4'h0;
                    tdm_data_clock <= !tdm_data_clock;
                end else begin
                    dcl_cnt_r <= dcl_cnt_r + 4'h1;
                end
            end
        end
    end

    //==========================================================
    // Frequency reference pin direction
    logic fref_meta_r;
    logic fref_sync_r;

    assign frequency_reference_pin_oe = nt_mode && host_mode
                                      && mode_ctrl_r[`MSRC_FREF_OUT_EN_BIT];
    assign frequency_reference_pin_o  = frequency_reference_pin_oe && receive_frame_sync;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fref_meta_r   <= 1'b0;
            fref_sync_r   <= 1'b0;
            fref_in_valid <= 1'b0;
        end else if (ce) begin
            fref_meta_r   <= frequency_reference_pin_i;
            fref_sync_r   <= fref_meta_r;
            fref_in_valid <= !nt_mode && fref_sync_r;
        end
    end

    //==========================================================
    // Checks
    sequence reset_seen_s;
        core_reset;
    endsequence

    sequence clocks_quiet_s;
        !tdm_data_clock && !receive_frame_sync;
    endsequence

    clk_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce and reset_seen_s) |=> clocks_quiet_s) else $error("clocks run in reset");
    reg_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && core_reset |=> byte_reg8_r == 8'h00 && mode_ctrl_r == 8'h00)
        else $error("register kept in reset");
    term_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
        line_terminate == core_reset && wakeup_detect_en == !core_reset)
        else $error("termination wrong");
    soft_rst_a: assert property (@(posedge aclk) disable iff (!aresetn)
        soft_reset_holder_r[3] |-> core_reset) else $error("soft reset ignored");
    hw_rst_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !hw_reset_n ##1 ce && !hw_reset_n |=> core_reset)
        else $error("hw reset ignored");
    nt_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !byte_reg8_r[1] |-> nt_mode == network_or_line_select)
        else $error("nt strap ignored");
    port_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !(parallel_port_en && serial_port_en) && (host_mode || !serial_port_en))
        else $error("port select wrong");
    fref_dir_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !nt_mode |-> !frequency_reference_pin_oe) else $error("fref driven in lt");
    fmt_bus_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !host_mode |-> link_format == 2'd2) else $error("bus format wrong");
    fref_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
        nt_mode && host_mode && mode_ctrl_r[0] |-> frequency_reference_pin_oe)
        else $error("fref not enabled");
endmodule

// file: verif/msrc_board_model.sv
`timescale 1ns/1ps

module msrc_board_model #(
    parameter int HOLD_MIN = 15,
    parameter int REF_HALF = 40
) (
    // Clock
    input  wire logic aclk,
    // Requests from the bench
    input  wire logic nt_req,
    input  wire logic host_req,
    input  wire logic par_req,
    input  wire logic mt_req,
    input  wire logic rst_req,
    // Frequency reference pin from the device
    input  wire logic fref_o,
    input  wire logic fref_oe,
    // Board side
    output logic      hw_reset_n,
    output logic      network_or_line_select,
    output logic      host_or_bus_mode_select,
    output logic      parallel_serial_select,
    output logic      master_timing,
    output wire logic fref_pin
);
    int   low_cnt = 0;
    int   ref_cnt = 0;
    logic ref_clk = 1'b0;

    // Reset held low at least six oscillator periods
    always_ff @(posedge aclk) begin
        if (rst_req) begin
            hw_reset_n <= 1'b0;
            low_cnt    <= 0;
        end else if (low_cnt < HOLD_MIN) begin
            low_cnt <= low_cnt + 1;
        end else begin
            hw_reset_n <= 1'b1;
        end
    end

    // Reference clock while the device does not drive the pin
    always_ff @(posedge aclk) begin
        ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
        if (ref_cnt == REF_HALF - 1) begin
            ref_clk <= ~ref_clk;
        end
    end

    assign network_or_line_select  = nt_req;
    assign host_or_bus_mode_select = host_req;
    assign parallel_serial_select  = host_req ? par_req : 1'b0;
    assign master_timing           = mt_req;
    assign fref_pin                = fref_oe ? fref_o : ref_clk;
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
`include "msrc_consts.svh"

module tb_top;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, link_format, resp, f;
    logic [31:0] rdata, rd;
    logic        nt_req = 0, host_req = 1, par_req = 0, mt_req = 1, rst_req = 1;
    logic        ce = 1'b1;
    logic        d0;
    logic        hw_reset_n, nt_sel, host_sel, par_sel, mt_sel;
    logic        core_reset, nt_mode, host_mode, par_en, ser_en, line_term, wake_en;
    logic        dclk, fsync, fref_o, fref_oe, fref_valid;
    logic [3:0]  es;
    wire         fref_pin;
    int          mismatches = 0, checked = 0, cycles = 0, n_hi;
    int          n_fs, n_dc, n_pin, n_ref;

    initial forever #10 aclk = ~aclk;

    msrc_board_model board_u (.aclk(aclk), .nt_req(nt_req), .host_req(host_req),
        .par_req(par_req), .mt_req(mt_req), .rst_req(rst_req), .fref_o(fref_o),
        .fref_oe(fref_oe), .hw_reset_n(hw_reset_n), .network_or_line_select(nt_sel),
        .host_or_bus_mode_select(host_sel), .parallel_serial_select(par_sel),
        .master_timing(mt_sel), .fref_pin(fref_pin));

    msrc_top dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hw_reset_n(hw_reset_n),
        .network_or_line_select(nt_sel), .host_or_bus_mode_select(host_sel),
        .parallel_serial_select(par_sel), .master_timing(mt_sel),
        .core_reset(core_reset), .nt_mode(nt_mode), .host_mode(host_mode),
        .parallel_port_en(par_en), .serial_port_en(ser_en), .link_format(link_format),
        .line_terminate(line_term), .wakeup_detect_en(wake_en),
        .tdm_data_clock(dclk), .receive_frame_sync(fsync),
        .frequency_reference_pin_i(fref_pin), .frequency_reference_pin_o(fref_o),
        .frequency_reference_pin_oe(fref_oe), .fref_in_valid(fref_valid));

    // ==========================================
    // Bench tasks
    task automatic summarize();
        $display("TB: %0d mismatches, %0d checked", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge aclk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        resp = bresp;
        bready <= 1'b0;
        if (n >= 100) mismatches++;
    endtask

    task automatic rdreg(input logic [7:0] a);
        int n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (n >= 100) mismatches++;
    endtask

    task automatic count_clocks(input int k);
        n_hi = 0;
        n_fs = 0;
        n_dc = 0;
        n_pin = 0;
        n_ref = 0;
        repeat (k) begin
            @(posedge aclk);
            if (dclk !== 1'b0 || fsync !== 1'b0) n_hi++;
            if (fsync === 1'b1) n_fs++;
            if (dclk === 1'b1) n_dc++;
            if (fref_pin === 1'b1) n_pin++;
            if (fref_valid === 1'b1) n_ref++;
        end
    endtask

    // Status bits: port enable, host, network side, reset
    function automatic logic [3:0] exp_status(input logic nt, host, par);
        return {host & par, host, nt, 1'b0};
    endfunction

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end

    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(32'ha67f_750f));
        repeat (2) @(posedge aclk);
        rst_req <= 1'b0;
        repeat (18) @(posedge aclk);
        aresetn <= 1'b1;
        idle(20);
        rdreg(`MSRC_ADDR_MODE_CTRL);
        check(rd, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            @(posedge aclk);
            nt_req <= i[0];
            host_req <= i[1];
            par_req <= i[2];
            idle(3);
            es = exp_status(i[0], i[1], i[2] & i[1]);
            check(32'({par_en, host_mode, nt_mode, core_reset}), 32'(es));
            check(32'(ser_en), 32'(i[1] & ~i[2]));
            rdreg(`MSRC_ADDR_STATUS);
            check(32'(rd[3:0]), 32'(es));
        end
        host_req <= 1'b1;
        nt_req <= 1'b0;
        wr(`MSRC_ADDR_BYTE_REG8, 32'h0000_0003);
        idle(2);
        check(32'(nt_mode), 32'h0000_0001);
        wr(`MSRC_ADDR_BYTE_REG8, 32'h0000_0002);
        wr(`MSRC_ADDR_MODE_CTRL, 32'h0000_0001);
        idle(2);
        check(32'({nt_mode, fref_oe}), 32'h0000_0000);
        wr(`MSRC_ADDR_BYTE_REG8, 32'h0000_0000);
        nt_req <= 1'b1;
        idle(3);
        check(32'(fref_oe), 32'h0000_0001);
        wr(`MSRC_ADDR_MODE_CTRL, 32'h0000_0000);
        idle(2);
        check(32'(fref_oe), 32'h0000_0000);
        for (int i = 0; i < 12; i++) begin
            f = (i < 4) ? i[1:0] : 2'($urandom);
            wr(`MSRC_ADDR_MODE_CTRL, {29'h0, f, 1'b0});
            idle(1);
            check(32'(link_format), 32'(f));
            rdreg(`MSRC_ADDR_MODE_CTRL);
            check(32'(rd[2:1]), 32'(f));
        end
        wr(`MSRC_ADDR_MODE_CTRL, 32'h0000_0005);
        wr(`MSRC_ADDR_SOFT_RESET, 32'h0000_0008);
        idle(2);
        check(32'(core_reset), 32'h0000_0001);
        check(32'({line_term, wake_en}), 32'h0000_0002);
        count_clocks(30);
        check(n_hi, 32'h0000_0000);
        rdreg(`MSRC_ADDR_MODE_CTRL);
        check(rd, 32'h0000_0000);
        rdreg(`MSRC_ADDR_SOFT_RESET);
        check(rd, 32'h0000_0008);
        wr(`MSRC_ADDR_SOFT_RESET, 32'h0000_0000);
        idle(2);
        check(32'(core_reset), 32'h0000_0000);
        // One whole frame with the reference pin driven
        wr(`MSRC_ADDR_MODE_CTRL, 32'h0000_0001);
        count_clocks(`MSRC_FRAME_DIV + 1);
        check(32'(n_hi != 0), 32'h0000_0001);
        check(n_fs, 32'h0000_0001);
        check(n_dc, (`MSRC_FRAME_DIV + 1) / 2);
        check(n_pin, 32'h0000_0001);
        check(n_ref, 32'h0000_0000);
        // Line side: pin is an input, sampled reference follows it
        nt_req <= 1'b0;
        idle(5);
        count_clocks(160);
        check(32'(fref_oe), 32'h0000_0000);
        check(n_ref, 32'h0000_0050);
        // Clock enable low freezes state and holds bus readies low
        ce <= 1'b0;
        idle(1);
        d0 = dclk;
        idle(5);
        check(32'({awready, arready, dclk}), 32'(d0));
        @(posedge aclk);
        ce <= 1'b1;
        mt_req <= 1'b0;
        idle(2);
        count_clocks(30);
        check(n_hi, 32'h0000_0000);
        wr(`MSRC_ADDR_MODE_CTRL, 32'h0000_0003);
        rst_req <= 1'b1;
        idle(5);
        check(32'(core_reset), 32'h0000_0001);
        check(32'({line_term, wake_en}), 32'h0000_0002);
        rdreg(`MSRC_ADDR_MODE_CTRL);
        check(rd, 32'h0000_0000);
        rst_req <= 1'b0;
        idle(25);
        check(32'(core_reset), 32'h0000_0000);
        wr(8'h40, 32'h0000_0001);
        check(32'(resp), 32'h0000_0002);
        rdreg(8'h40);
        check({rd[29:0], resp}, 32'h0000_0002);
        summarize();
    end
endmodule
